/* File: core/sdwl_pkg.sv */
package sdwl_pkg;
  localparam int WORD_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] WORD_EDGES = 5'h10;
  localparam int CHAN_NUM = 8;
  localparam int CHAN_BITS = 3;
  localparam int DATA_BITS = 10;
  // Word layout: two mode bits, three channel bits, data in the low bits
  localparam int MODE_MSB = 15;
  localparam int MODE_LSB = 14;
  localparam int CHAN_MSB = 12;
  localparam int CHAN_LSB = 10;
  localparam logic [1:0] MODE_MAIN_DATA = 2'h0;
  localparam logic [DATA_BITS-1:0] DATA_RESET = 10'h000;
  localparam int FIFO_DEPTH = 4;
endpackage

/* File: core/sdwl_fifo.sv */
`timescale 1ns/1ps
module sdwl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } sdwl_fifo_t;
  sdwl_fifo_t s_r;
  sdwl_fifo_t s_nxt;
  logic push;
  logic pop;

  always_comb begin
    s_nxt = s_r;
    push = in_valid && (s_r.cnt != (AW+1)'(DEPTH));
    pop = out_valid && out_ready;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr = (s_r.wr == AW'(DEPTH-1)) ? '0 : s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = (s_r.rd == AW'(DEPTH-1)) ? '0 : s_r.rd + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rd];
endmodule

/* File: core/sdwl_top.sv */
`timescale 1ns/1ps
// Function
// RULE_01 - Data sampled into shift register on falling serial clock while frame low.
// RULE_02 - One write is one 16-bit word framed by low frame sync.
// RULE_03 - Byte hosts keep frame low across two bytes; sixteen edges make a word.
// RULE_04 - Data arrives most significant bit first.
// RULE_05 - Host changes data on rising clock edge, stable at falling edge.
// RULE_06 - Update held low loads addressed DAC register after sixteenth edge.
// RULE_07 - Update pulse low copies all input registers to DAC registers.
// RULE_08 - Word accepted only while this device's own frame sync is low.
// RULE_09 - Host holds decoder enable inactive while decoder address changes.
// RULE_10 - Parallel hosts may decode the update strobe from an address.
// RULE_11 - Leading word bits select register and channel, e.g. 23FF.
// RULE_12 - Frame rising before sixteen edges discards the partial word.
module sdwl_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic SERIAL_DATA_IN,
  input wire logic FRAME_SYNC_N,
  input wire logic OUTPUT_UPDATE_N,
  input wire logic CLEAR_OUTPUTS_N,
  output logic [sdwl_pkg::CHAN_NUM*sdwl_pkg::DATA_BITS-1:0] DAC_VALUES,
  output logic WORD_OVERRUN
);
  localparam int CN = sdwl_pkg::CHAN_NUM;
  localparam int DB = sdwl_pkg::DATA_BITS;
  localparam int WB = sdwl_pkg::WORD_BITS;

  // Link domain: shifter on falling serial clock
  typedef struct packed {
    logic [WB-1:0] shift;
    logic [sdwl_pkg::CNT_BITS-1:0] cnt;
    logic [WB-1:0] word;
    logic tog;
  } sdwl_link_t;
  sdwl_link_t l_r;
  sdwl_link_t l_nxt;
  logic fs_async;

  assign fs_async = FRAME_SYNC_N;

  always_comb begin
    l_nxt = l_r;
    if (!FRAME_SYNC_N) begin // see RULE_08
      l_nxt.shift = {l_r.shift[WB-2:0], SERIAL_DATA_IN}; // see RULE_01 see RULE_04
      l_nxt.cnt = l_r.cnt + 5'h01;
      if (l_r.cnt == sdwl_pkg::WORD_EDGES - 5'h01) begin // see RULE_02 see RULE_03
        l_nxt.word = {l_r.shift[WB-2:0], SERIAL_DATA_IN};
        l_nxt.tog = ~l_r.tog;
        l_nxt.cnt = 5'h00;
      end
    end
  end

  // Frame high resets count asynchronously: partial words die
  always_ff @(negedge SERIAL_CLOCK_IN or negedge RST_N or posedge fs_async) begin
    if (!RST_N) begin
      l_r <= '0;
    end else if (fs_async) begin
      l_r.cnt <= 5'h00; // see RULE_12
    end else begin
      l_r <= l_nxt;
    end
  end

  // System domain
  typedef struct packed {
    logic [2:0] tog_s;
    logic [1:0] upd_s;
    logic [1:0] clr_s;
    logic [CN-1:0][DB-1:0] inreg;
    logic [CN-1:0][DB-1:0] dac;
    logic [CN-1:0] pend;
    logic ovr;
  } sdwl_sys_t;
  sdwl_sys_t s_r;
  sdwl_sys_t s_nxt;
  logic in_valid;
  logic in_ready;
  logic out_valid;
  logic [WB-1:0] out_data;
  logic [CN-1:0] load;
  logic [sdwl_pkg::CHAN_BITS-1:0] word_chan;
  logic word_main;
  logic upd_low;

  // Word captured in link domain stays stable for a full word time after toggle
  assign in_valid = s_r.tog_s[2] ^ s_r.tog_s[1];

  sdwl_fifo #(.WIDTH(WB), .DEPTH(sdwl_pkg::FIFO_DEPTH)) u_fifo (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(l_r.word),
    .out_valid(out_valid),
    .out_ready(1'b1),
    .out_data(out_data)
  );

  // Word fields from the FIFO head
  assign word_chan = out_data[sdwl_pkg::CHAN_MSB:sdwl_pkg::CHAN_LSB];
  assign word_main = out_valid
      && (out_data[sdwl_pkg::MODE_MSB:sdwl_pkg::MODE_LSB] == sdwl_pkg::MODE_MAIN_DATA);
  assign upd_low = !s_r.upd_s[1];

  // Per-channel transfer of a pending input register
  generate
    for (genvar g = 0; g < CN; g++) begin : g_load
      assign load[g] = upd_low && s_r.pend[g]; // see RULE_06 see RULE_07
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    s_nxt.tog_s = {s_r.tog_s[1:0], l_r.tog};
    s_nxt.upd_s = {s_r.upd_s[0], OUTPUT_UPDATE_N};
    s_nxt.clr_s = {s_r.clr_s[0], CLEAR_OUTPUTS_N};
    s_nxt.ovr = s_r.ovr | (in_valid && !in_ready);
    for (int i = 0; i < CN; i++) begin
      if (load[i]) begin
        s_nxt.dac[i] = s_r.inreg[i];
        s_nxt.pend[i] = 1'b0;
      end
    end
    // New word after the copy, so its pending flag survives
    if (word_main) begin // see RULE_11
      s_nxt.inreg[word_chan] = out_data[DB-1:0];
      s_nxt.pend[word_chan] = 1'b1;
    end
    if (!s_r.clr_s[1]) begin
      s_nxt.dac = '0;
      s_nxt.inreg = '0;
      s_nxt.pend = '0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '0;
      s_r.upd_s <= 2'h3;
      s_r.clr_s <= 2'h3;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DAC_VALUES <= '0;
      WORD_OVERRUN <= 1'b0;
    end else begin
      DAC_VALUES <= s_nxt.dac;
      WORD_OVERRUN <= s_nxt.ovr;
    end
  end
endmodule

/* File: bench/sdwl_chk_assertions.sv */
`timescale 1ns/1ps
module sdwl_chk (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic SERIAL_DATA_IN,
  input wire logic FRAME_SYNC_N,
  input wire logic OUTPUT_UPDATE_N,
  input wire logic CLEAR_OUTPUTS_N,
  input wire logic [79:0] DAC_VALUES,
  input wire logic WORD_OVERRUN
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_idle_hold:
    assert property ((OUTPUT_UPDATE_N && CLEAR_OUTPUTS_N) [*8] |=> $stable(DAC_VALUES))
    else $error("dac moved without update");
  a_frame_quiet:
    assert property ((FRAME_SYNC_N && !OUTPUT_UPDATE_N && CLEAR_OUTPUTS_N) [*8]
      |=> $stable(DAC_VALUES))
    else $error("dac moved without frame");
  a_defer_hold:
    assert property ((OUTPUT_UPDATE_N && CLEAR_OUTPUTS_N) [*3] |=> $stable(DAC_VALUES))
    else $error("dac moved with update high");
  a_change_cause:
    assert property ($changed(DAC_VALUES)
      |-> (!$past(OUTPUT_UPDATE_N, 3) || !$past(CLEAR_OUTPUTS_N, 3)))
    else $error("dac changed with no update or clear");
  a_clear_zero:
    assert property ((!CLEAR_OUTPUTS_N) [*3] |=> (DAC_VALUES == 80'h0))
    else $error("dac not zero under clear");
  a_overrun_none:
    assert property (!WORD_OVERRUN)
    else $error("word dropped");
endmodule
bind sdwl_top sdwl_chk chk (.*);

/* File: bench/sdwl_host.sv */
`timescale 1ns/1ps
module sdwl_host (
  output logic sclk,
  output logic sdo,
  output logic fs_n
);
  initial begin
    sclk = 0;
    sdo = 0;
    fs_n = 1;
  end
  // Sends n bits from the top of w; hold keeps the frame open
  task automatic send(input logic [15:0] w, input int n, input logic hold);
    fs_n = 0;
    #16;
    for (int i = 15; i > 15 - n; i--) begin
      sclk = 1;
      sdo = w[i];
      #16;
      sclk = 0;
      #16;
    end
    sdo = ~sdo;
    #16;
    fs_n = !hold;
    #16;
  endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH %0t got %h", $time, a); end end
module testbench;
  logic clk = 0, rst_n = 0, upd_n = 1, clr_n = 1, sclk, sdo, fs_n, ovr;
  logic [79:0] dac;
  int fails = 0, n_compared = 0;
  always #10 clk = ~clk;
  sdwl_host host (.sclk(sclk), .sdo(sdo), .fs_n(fs_n));
  sdwl_top uut (.REF_CLK(clk), .RST_N(rst_n), .SERIAL_CLOCK_IN(sclk), .SERIAL_DATA_IN(sdo),
    .FRAME_SYNC_N(fs_n), .OUTPUT_UPDATE_N(upd_n), .CLEAR_OUTPUTS_N(clr_n),
    .DAC_VALUES(dac), .WORD_OVERRUN(ovr));
  task automatic wt;
    repeat (12) @(posedge clk);
    #1;
  endtask
  task automatic set_upd(input logic v);
    @(posedge clk);
    upd_n <= v;
  endtask
  task automatic t_auto;
    set_upd(0);
    host.send(16'h23FF, 16, 0);
    wt;
    `CHK(dac[9:0], 10'h3FF)
    host.send(16'h1555, 16, 0);
    wt;
    `CHK(dac[59:50], 10'h155)
  endtask
  task automatic t_bytes;
    host.send(16'h0800, 8, 1);
    host.send(16'hAA00, 8, 0);
    wt;
    `CHK(dac[29:20], 10'h0AA)
  endtask
  task automatic t_refuse;
    host.send(16'h0C33, 12, 0);
    host.send(16'h4C33, 16, 0);
    wt;
    `CHK(dac[39:30], 10'h000)
  endtask
  task automatic t_defer;
    set_upd(1);
    wt;
    host.send(16'h0511, 16, 0);
    host.send(16'h1D22, 16, 0);
    wt;
    `CHK(dac[19:10], 10'h000)
    set_upd(0);
    set_upd(1);
    wt;
    `CHK(dac[79:70], 10'h122)
    `CHK(dac[19:10], 10'h111)
    `CHK(ovr, 1'h0)
  endtask
  task automatic t_clear;
    @(posedge clk);
    clr_n <= 0;
    wt;
    `CHK(dac, 80'h0)
    @(posedge clk);
    clr_n <= 1;
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    t_auto;
    t_bytes;
    t_refuse;
    t_defer;
    t_clear;
    complete_run;
  end
  initial begin
    #200000;
    fails++;
    complete_run;
  end
endmodule
